// *** dv/tb.sv ***
// Self-checking bench for the timed pattern output block
`timescale 1ns/100ps
`include "pattern_params.svh"
module tb;
   logic clock;
   logic rst;
   logic hw_standby;
   pattern_pkg::apb_req_s req;
   pattern_pkg::apb_rsp_s rsp;
   logic [2:0] start;
   logic [2:0] cm;
   logic [3:0] delay;
   logic [15:0] pulse_out;
   logic [15:0] q;
   logic [15:0] pin_dir;
   int mismatches;
   int check_count;

   pulse_pattern uut (.clock(clock), .rst(rst), .hw_standby(hw_standby), .apb_in(req),
      .apb_out(rsp), .compare_match(cm), .pulse_out(pulse_out));
   timer_model timers (.clock(clock), .rst(rst), .start(start), .delay(delay),
      .compare_match(cm));

   task results;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   // One transfer; q gets {error, data} taken at the edge that samples pready
   task apb(input logic w, input logic [21:0] idx, input logic [7:0] d);
      int n;
      @(posedge clock);
      req <= '{1'b1, 1'b0, w, {idx, 2'h0}, {24'h000000, d}};
      @(posedge clock);
      req.penable <= 1'b1;
      n = 0;
      @(posedge clock);
      while (rsp.pready !== 1'b1 && n < 16)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 16)
      begin
         mismatches++;
         results;
      end
      else
      begin
         q = {7'h00, rsp.pslverr, rsp.prdata[7:0]};
         req.psel <= 1'b0;
         req.penable <= 1'b0;
      end
   endtask : apb

   task trig(input int ch, input logic [3:0] d);
      int n;
      @(posedge clock);
      start <= 3'h1 << ch;
      delay <= d;
      @(posedge clock);
      start <= 3'h0;
      n = 0;
      while (cm === 3'h0 && n < 32)
      begin
         @(posedge clock);
         n++;
      end
      if (n >= 32)
      begin
         mismatches++;
         results;
      end
      else
      begin
         repeat (2) @(posedge clock);
         #1;
      end
   endtask : trig

   task t_init;
      apb(1'b0, `IDX_ENABLE_LOW, 8'h00);
      chk("enable_low", q, 16'h0000);
      apb(1'b0, `IDX_ENABLE_HIGH, 8'h00);
      chk("enable_high", q, 16'h0000);
      apb(1'b0, `IDX_TRIGGER_SELECT, 8'h00);
      chk("trigger_select", q, 16'h00FF);
      apb(1'b1, 22'h0FFFA3, 8'h5A);
      chk("unmapped", q, 16'h0100);
      chk("pulse_out", pulse_out & pin_dir, 16'h0000);
   endtask : t_init

   // Groups 3 and 0 on channel 0, group 1 on 1, group 2 on 2
   task t_split;
      apb(1'b1, `IDX_TRIGGER_SELECT, 8'h24);
      apb(1'b1, `IDX_ENABLE_LOW, 8'hFF);
      apb(1'b1, `IDX_ENABLE_HIGH, 8'hFF);
      apb(1'b1, `IDX_NEXT_LOW, 8'hA5);
      apb(1'b1, `IDX_NEXT_HIGH, 8'hC0);
      apb(1'b1, `IDX_NEXT_GROUP2, 8'h03);
      apb(1'b0, `IDX_NEXT_GROUP2, 8'h00);
      chk("group2 next", q, 16'h00F3);
      trig(0, 4'h0);
      chk("after ch0", pulse_out, 16'hC005);
      trig(1, 4'h5);
      chk("after ch1", pulse_out, 16'hC0A5);
      trig(2, 4'h0);
      chk("after ch2", pulse_out, 16'hC3A5);
      apb(1'b1, `IDX_PORT_B_DATA, 8'h00);
      apb(1'b0, `IDX_PORT_B_DATA, 8'h00);
      chk("port_b_data", q, 16'h00C3);
   endtask : t_split

   // Every select code, with the unselected channel fired first
   task t_codes;
      logic [7:0] prev;
      prev = 8'hA5;
      for (int c = 0; c < 4; c++)
      begin
         int ch;
         logic [7:0] v;
         ch = (c > 1) ? 2 : c;
         v = 8'(17 * (c + 1));
         apb(1'b1, `IDX_TRIGGER_SELECT, {4{c[1:0]}});
         apb(1'b1, `IDX_NEXT_LOW, v);
         trig((ch + 1) % 3, 4'h1);
         chk("unselected", {8'h00, pulse_out[7:0]}, {8'h00, prev});
         trig(ch, 4'h2);
         chk("selected", {8'h00, pulse_out[7:0]}, {8'h00, v});
         prev = v;
      end
   endtask : t_codes

   task t_partial;
      apb(1'b1, `IDX_ENABLE_LOW, 8'h0F);
      apb(1'b1, `IDX_ENABLE_HIGH, 8'h0F);
      apb(1'b1, `IDX_NEXT_LOW, 8'hFF);
      apb(1'b1, `IDX_NEXT_HIGH, 8'h3C);
      trig(2, 4'h0);
      chk("partial", pulse_out, 16'hCC4F);
   endtask : t_partial

   task t_standby;
      @(posedge clock);
      hw_standby <= 1'b1;
      repeat (4) @(posedge clock);
      hw_standby <= 1'b0;
      repeat (3) @(posedge clock);
      chk("standby out", pulse_out, 16'h0000);
      apb(1'b0, `IDX_ENABLE_LOW, 8'h00);
      chk("standby low", q, 16'h0000);
      apb(1'b0, `IDX_ENABLE_HIGH, 8'h00);
      chk("standby high", q, 16'h0000);
      apb(1'b0, `IDX_TRIGGER_SELECT, 8'h00);
      chk("standby sel", q, 16'h00FF);
      // Port data written while disabled must show as soon as the bits are enabled
      apb(1'b1, `IDX_PORT_A_DATA, 8'h3C);
      apb(1'b1, `IDX_ENABLE_LOW, 8'h0F);
      chk("fresh enable", pulse_out & pin_dir, 16'h003C);
   endtask : t_standby

   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      rst = 1'b1;
      hw_standby = 1'b0;
      req = '0;
      start = 3'h0;
      delay = 4'h0;
      pin_dir = 16'hFFFF; // Every pattern pin is set as output
      mismatches = 0;
      check_count = 0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      t_init;
      $display("test init done");
      t_split;
      $display("test split done");
      t_codes;
      $display("test codes done");
      t_partial;
      $display("test partial done");
      t_standby;
      $display("test standby done");
      results;
   end
endmodule : tb

// *** dv/timer_model.sv ***
// Behavioural timer channels that issue one-cycle compare-match strobes
`timescale 1ns/100ps
module timer_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [2:0] start,
   input wire logic [3:0] delay,
   output logic [2:0] compare_match
);
   logic [2:0] pend;
   logic [3:0] cnt;
   // A slow channel waits delay cycles, so prompt and late strobes both occur
   always_ff @(posedge clock)
   begin
      compare_match <= 3'h0;
      if (rst)
      begin
         pend <= 3'h0;
         cnt <= 4'h0;
      end
      else if (start != 3'h0)
      begin
         pend <= start;
         cnt <= delay;
      end
      else if (pend != 3'h0)
      begin
         if (cnt == 4'h0)
         begin
            compare_match <= pend;
            pend <= 3'h0;
         end
         else
            cnt <= cnt - 4'h1;
      end
   end
endmodule : timer_model

// *** src/pattern_params.svh ***
// Constants for the timed pattern output block: offsets, fields, reset values
`ifndef PATTERN_PARAMS_SVH
`define PATTERN_PARAMS_SVH
`define ADDR_W 24
`define IDX_W 22
`define IDX_ENABLE_LOW 22'h0FFFA0
`define IDX_ENABLE_HIGH 22'h0FFFA1
`define IDX_TRIGGER_SELECT 22'h0FFFA2
`define IDX_NEXT_LOW 22'h0FFFA5
`define IDX_NEXT_HIGH 22'h0FFFA4
`define IDX_NEXT_GROUP2 22'h0FFFA6
`define IDX_PORT_A_DATA 22'h0FFFA8
`define IDX_PORT_B_DATA 22'h0FFFA9
`define GROUP_W 4
`define SEL_W 2
`define SEL_CH2 2'h2
`define ENABLE_RESET 8'h00
`define TRIGGER_SELECT_RESET 8'hFF
`define NEXT_DATA_RESET 8'h00
`define PORT_DATA_RESET 8'h00
`define RESERVED_ONES 4'hF
`define ALL_ONES 8'hFF
`endif

// *** src/pattern_pkg.sv ***
// Types shared by the timed pattern output block
`include "pattern_params.svh"
package pattern_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [`ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } apb_rsp_s;

   typedef struct packed {
      logic [7:0] enable_low;
      logic [7:0] enable_high;
      logic [7:0] trigger_select;
      logic [7:0] next_low;
      logic [7:0] next_high;
      logic [7:0] port_a;
      logic [7:0] port_b;
   } regs_s;

   typedef struct packed {
      logic standby_meta;
      logic standby_sync;
      regs_s regs;
      logic [31:0] prdata;
      logic pslverr;
   } state_s;
endpackage : pattern_pkg

// *** src/pulse_pattern.sv ***
// Timed pattern output: next-data transfer into port data on compare match
`timescale 1ns/100ps
`include "pattern_params.svh"
// Contract
// - Enabled port A bit takes its next-data bit when its group trigger fires.
// - Disabled port A bit is not updated by a trigger; output holds.
// - Low enable bit n gates next-data bit n into port A bit n.
// - Low enable register clears on reset and hardware standby only.
// - Enabled port B bit takes upper next-data bit when its group trigger fires.
// - Disabled port B bit is skipped on a trigger; output holds.
// - High enable bit n gates next-data bit n+8 into port B bit n.
// - High enable register clears on reset and hardware standby only.
// - Trigger select sets to all ones on reset and hardware standby only.
// - Select fields: 7-6 group 3, 5-4 group 2, 3-2 group 1, 1-0 group 0.
// - Field 00 picks channel 0, 01 channel 1, 10 and 11 channel 2.
// - Split triggers: group 2 next data in low nibble at second address, top reads ones.
// - Port B bits enabled for pulse output are read-only to software.
// - Before a trigger, an enabled output shows its current port data.
module pulse_pattern
(
   input wire logic clock,
   input wire logic rst,
   input wire logic hw_standby,
   input wire pattern_pkg::apb_req_s apb_in,
   output pattern_pkg::apb_rsp_s apb_out,
   input wire logic [2:0] compare_match,
   output logic [15:0] pulse_out
);
   localparam pattern_pkg::regs_s RESET_REGS = '{
      enable_low: `ENABLE_RESET,
      enable_high: `ENABLE_RESET,
      trigger_select: `TRIGGER_SELECT_RESET,
      next_low: `NEXT_DATA_RESET,
      next_high: `NEXT_DATA_RESET,
      port_a: `PORT_DATA_RESET,
      port_b: `PORT_DATA_RESET
   };
   localparam pattern_pkg::state_s RESET_STATE = '{
      standby_meta: 1'b0,
      standby_sync: 1'b0,
      regs: RESET_REGS,
      prdata: 32'h00000000,
      pslverr: 1'b0
   };

   pattern_pkg::state_s state;
   pattern_pkg::state_s next_state;
   logic [3:0] group_fire;
   logic [3:0][1:0] group_channel;
   logic [15:0] en16;
   logic [15:0] nd16;
   logic [15:0] pd16;
   logic [15:0] fire16;
   logic [15:0] upd16;
   logic [`IDX_W-1:0] idx;
   logic aligned;
   logic setup_phase;
   logic wr_access;
   logic same_upper;
   logic [8:0] read_result;

   trigger_route route
   (
      .trigger_select(state.regs.trigger_select),
      .compare_match(compare_match),
      .group_fire(group_fire),
      .group_channel(group_channel)
   );

   // Returns {mapped, byte}; reserved nibbles read as ones
   function automatic logic [8:0] read_reg(input logic [`IDX_W-1:0] i,
                                           input pattern_pkg::regs_s r,
                                           input logic same);
      case (i)
         `IDX_ENABLE_LOW: read_reg = {1'b1, r.enable_low};
         `IDX_ENABLE_HIGH: read_reg = {1'b1, r.enable_high};
         `IDX_TRIGGER_SELECT: read_reg = {1'b1, r.trigger_select};
         `IDX_NEXT_LOW: read_reg = {1'b1, r.next_low};
         `IDX_NEXT_HIGH:
            read_reg = same ? {1'b1, r.next_high} : {1'b1, r.next_high[7:4], `RESERVED_ONES};
         `IDX_NEXT_GROUP2:
            read_reg = same ? {1'b1, `ALL_ONES} : {1'b1, `RESERVED_ONES, r.next_high[3:0]};
         `IDX_PORT_A_DATA: read_reg = {1'b1, r.port_a};
         `IDX_PORT_B_DATA: read_reg = {1'b1, r.port_b};
         default: read_reg = 9'h000;
      endcase
   endfunction : read_reg

   assign en16 = {state.regs.enable_high, state.regs.enable_low};
   assign nd16 = {state.regs.next_high, state.regs.next_low};
   assign pd16 = {state.regs.port_b, state.regs.port_a};
   assign fire16 = {{`GROUP_W{group_fire[3]}}, {`GROUP_W{group_fire[2]}},
                    {`GROUP_W{group_fire[1]}}, {`GROUP_W{group_fire[0]}}};
   assign upd16 = en16 & fire16;
   assign idx = apb_in.paddr[`ADDR_W-1:2];
   assign aligned = (apb_in.paddr[1:0] == 2'h0);
   assign setup_phase = apb_in.psel && !apb_in.penable;
   // Zero wait states, so every access phase completes at its first edge
   assign wr_access = apb_in.psel && apb_in.penable && apb_in.pwrite && aligned;
   // Channel equality, not code equality: 10 and 11 are one trigger
   assign same_upper = (group_channel[3] == group_channel[2]);
   assign read_result = aligned ? read_reg(idx, state.regs, same_upper) : 9'h000;

   always_comb
   begin
      logic [7:0] wdata;
      logic [15:0] pd_mid;
      wdata = apb_in.pwdata[7:0];
      pd_mid = 16'h0000;
      next_state = state;
      next_state.standby_meta = hw_standby;
      next_state.standby_sync = state.standby_meta;
      if (setup_phase)
      begin
         next_state.pslverr = !read_result[8];
         next_state.prdata = apb_in.pwrite ? 32'h00000000 : {24'h000000, read_result[7:0]};
      end
      if (wr_access)
      begin
         case (idx)
            `IDX_ENABLE_LOW: next_state.regs.enable_low = wdata;
            `IDX_ENABLE_HIGH: next_state.regs.enable_high = wdata;
            `IDX_TRIGGER_SELECT: next_state.regs.trigger_select = wdata;
            `IDX_NEXT_LOW: next_state.regs.next_low = wdata;
            `IDX_NEXT_HIGH:
            begin
               next_state.regs.next_high[7:4] = wdata[7:4];
               if (same_upper)
                  next_state.regs.next_high[3:0] = wdata[3:0];
            end
            `IDX_NEXT_GROUP2:
            begin
               if (!same_upper)
                  next_state.regs.next_high[3:0] = wdata[3:0];
            end
            `IDX_PORT_A_DATA:
               next_state.regs.port_a = (state.regs.port_a & state.regs.enable_low)
                                      | (wdata & ~state.regs.enable_low);
            `IDX_PORT_B_DATA:
               next_state.regs.port_b = (state.regs.port_b & state.regs.enable_high)
                                      | (wdata & ~state.regs.enable_high);
            default: next_state.regs = next_state.regs;
         endcase
      end
      // The transfer uses next data as it stood before any write in this cycle
      pd_mid = {next_state.regs.port_b, next_state.regs.port_a};
      pd_mid = (pd_mid & ~upd16) | (nd16 & upd16);
      next_state.regs.port_a = pd_mid[7:0];
      next_state.regs.port_b = pd_mid[15:8];
      if (state.standby_sync)
         next_state.regs = RESET_REGS;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         state <= RESET_STATE;
      else
         state <= next_state;
   end

   // Pins follow port data directly, so a fresh enable shows old data first
   assign pulse_out = pd16;
   // One driver for the whole response struct
   assign apb_out = '{prdata: state.prdata, pready: 1'b1, pslverr: state.pslverr};

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   logic any_write;
   logic quiet;
   assign any_write = apb_in.psel && apb_in.penable && apb_in.pwrite;
   assign quiet = !any_write && !state.standby_sync;

   chk_transfer_enabled: assert property (
      (upd16 != 16'h0000) && quiet |=> (pd16 & $past(upd16)) == ($past(nd16) & $past(upd16)))
      else $error("enabled bit missed its next-data transfer");

   chk_disabled_hold: assert property (
      quiet |=> (pd16 & ~$past(upd16)) == ($past(pd16) & ~$past(upd16)))
      else $error("bit without transfer changed");

   chk_low_bit_map: assert property (
      group_fire[1] && state.regs.enable_low[7] && quiet |=> pulse_out[7] == $past(nd16[7]))
      else $error("low enable bit 7 did not move next bit 7");

   chk_high_bit_map: assert property (
      group_fire[2] && state.regs.enable_high[0] && quiet |=> pulse_out[8] == $past(nd16[8]))
      else $error("high enable bit 0 did not move next bit 8");

   chk_reset_values: assert property (@(posedge clock) disable iff (1'b0)
      $past(rst) || (!rst && $past(state.standby_sync)) |->
         state.regs.enable_low == `ENABLE_RESET && state.regs.enable_high == `ENABLE_RESET
         && state.regs.trigger_select == `TRIGGER_SELECT_RESET)
      else $error("control registers not initialised");

   chk_chan0_select: assert property (
      compare_match == 3'b001 |->
         group_fire[0] == (state.regs.trigger_select[1:0] == 2'h0)
         && group_fire[3] == (state.regs.trigger_select[7:6] == 2'h0))
      else $error("channel 0 strobe routed wrongly");

   chk_chan2_select: assert property (
      compare_match == 3'b100 && state.regs.trigger_select[5] |-> group_fire[2])
      else $error("channel 2 strobe did not reach group 2");

   chk_shared_channel: assert property (
      state.regs.trigger_select[7:6] == state.regs.trigger_select[5:4]
         |-> group_fire[3] == group_fire[2])
      else $error("groups on one channel fired apart");

   chk_group2_read: assert property (
      setup_phase && !apb_in.pwrite && aligned && idx == `IDX_NEXT_GROUP2 && !same_upper
         |=> apb_out.prdata[7:0] == {`RESERVED_ONES, $past(state.regs.next_high[3:0])})
      else $error("group 2 next data read wrong");

   chk_port_b_readonly: assert property (
      wr_access && idx == `IDX_PORT_B_DATA && !group_fire[3] && !group_fire[2]
         && !state.standby_sync
         |=> (state.regs.port_b & $past(state.regs.enable_high))
             == ($past(state.regs.port_b) & $past(state.regs.enable_high)))
      else $error("enabled port B bit was written by software");

   chk_output_stable: assert property (
      group_fire == 4'h0 && quiet |=> $stable(pulse_out))
      else $error("output moved without trigger or write");

   chk_low_enable_write: assert property (
      wr_access && idx == `IDX_ENABLE_LOW && !state.standby_sync
         |=> state.regs.enable_low == $past(apb_in.pwdata[7:0]))
      else $error("low enable register write lost");

   chk_high_enable_write: assert property (
      wr_access && idx == `IDX_ENABLE_HIGH && !state.standby_sync
         |=> state.regs.enable_high == $past(apb_in.pwdata[7:0]))
      else $error("high enable register write lost");

   chk_select_write: assert property (
      wr_access && idx == `IDX_TRIGGER_SELECT && !state.standby_sync
         |=> state.regs.trigger_select == $past(apb_in.pwdata[7:0]))
      else $error("trigger select write lost");

   chk_low_enable_keep: assert property (
      !any_write && !state.standby_sync |=> $stable(state.regs.enable_low))
      else $error("low enable register changed on its own");

   chk_high_enable_keep: assert property (
      !any_write && !state.standby_sync |=> $stable(state.regs.enable_high))
      else $error("high enable register changed on its own");

   chk_select_keep: assert property (
      !any_write && !state.standby_sync |=> $stable(state.regs.trigger_select))
      else $error("trigger select changed on its own");

   chk_chan1_select: assert property (
      compare_match == 3'h2 |->
         group_fire[1] == (state.regs.trigger_select[3:2] == 2'h1)
         && group_fire[2] == (state.regs.trigger_select[5:4] == 2'h1))
      else $error("channel 1 strobe routed wrongly");

   chk_chan2_codes: assert property (
      compare_match == 3'h4 |->
         group_fire[0] == state.regs.trigger_select[1]
         && group_fire[3] == state.regs.trigger_select[7])
      else $error("channel 2 strobe routed wrongly");

   chk_no_strobe: assert property (
      compare_match == 3'h0 |-> group_fire == 4'h0)
      else $error("group fired without a strobe");

   chk_group0_map: assert property (
      group_fire[0] && state.regs.enable_low[0] && quiet |=> pulse_out[0] == $past(nd16[0]))
      else $error("low enable bit 0 did not move next bit 0");

   chk_group1_map: assert property (
      group_fire[1] && state.regs.enable_low[4] && quiet |=> pulse_out[4] == $past(nd16[4]))
      else $error("low enable bit 4 did not move next bit 4");

   chk_group2_map: assert property (
      group_fire[2] && state.regs.enable_high[3] && quiet
         |=> pulse_out[11] == $past(nd16[11]))
      else $error("high enable bit 3 did not move next bit 11");

   chk_group3_map: assert property (
      group_fire[3] && state.regs.enable_high[7] && quiet
         |=> pulse_out[15] == $past(nd16[15]))
      else $error("high enable bit 7 did not move next bit 15");

   chk_low_disabled: assert property (
      group_fire[0] && !state.regs.enable_low[0] && quiet |=> $stable(pulse_out[0]))
      else $error("disabled low bit moved on a trigger");

   chk_high_disabled: assert property (
      group_fire[3] && !state.regs.enable_high[7] && quiet |=> $stable(pulse_out[15]))
      else $error("disabled high bit moved on a trigger");

   chk_low_scope: assert property (
      group_fire[1:0] == 2'h0 && quiet |=> $stable(pulse_out[7:0]))
      else $error("low groups moved without their trigger");

   chk_high_scope: assert property (
      group_fire[3:2] == 2'h0 && quiet |=> $stable(pulse_out[15:8]))
      else $error("high groups moved without their trigger");

   chk_split_high_write: assert property (
      wr_access && idx == `IDX_NEXT_HIGH && !same_upper && !state.standby_sync
         |=> state.regs.next_high
             == {$past(apb_in.pwdata[7:4]), $past(state.regs.next_high[3:0])})
      else $error("split upper next data write wrong");

   chk_group2_write: assert property (
      wr_access && idx == `IDX_NEXT_GROUP2 && !same_upper && !state.standby_sync
         |=> state.regs.next_high
             == {$past(state.regs.next_high[7:4]), $past(apb_in.pwdata[3:0])})
      else $error("group 2 next data write wrong");

   chk_group2_locked: assert property (
      wr_access && idx == `IDX_NEXT_GROUP2 && same_upper && !state.standby_sync
         |=> $stable(state.regs.next_high))
      else $error("reserved group 2 address took a write");

   chk_next_high_keep: assert property (
      !any_write && !state.standby_sync |=> $stable(state.regs.next_high))
      else $error("upper next data changed on its own");

   chk_same_read: assert property (
      setup_phase && !apb_in.pwrite && aligned && idx == `IDX_NEXT_GROUP2 && same_upper
         |=> apb_out.prdata[7:0] == `ALL_ONES)
      else $error("reserved group 2 address read wrong");

   chk_high_read_split: assert property (
      setup_phase && !apb_in.pwrite && aligned && idx == `IDX_NEXT_HIGH && !same_upper
         |=> apb_out.prdata[7:0]
             == {$past(state.regs.next_high[7:4]), `RESERVED_ONES})
      else $error("split upper next data read wrong");

   chk_port_b_free: assert property (
      wr_access && idx == `IDX_PORT_B_DATA && !group_fire[3] && !group_fire[2]
         && !state.standby_sync
         |=> (state.regs.port_b & ~$past(state.regs.enable_high))
             == ($past(apb_in.pwdata[7:0]) & ~$past(state.regs.enable_high)))
      else $error("disabled port B bit missed a software write");

   chk_standby_clears: assert property (
      state.standby_sync
         |=> state.regs == RESET_REGS && pulse_out == 16'h0000)
      else $error("standby did not initialise the registers");

   chk_next_low_write: assert property (
      wr_access && idx == `IDX_NEXT_LOW && !state.standby_sync
         |=> state.regs.next_low == $past(apb_in.pwdata[7:0]))
      else $error("lower next data write lost");

   cov_transfer: cover property (upd16 != 16'h0000 ##1 upd16 != 16'h0000);
   cov_split_read: cover property (setup_phase && idx == `IDX_NEXT_GROUP2 && !same_upper);
   cov_ro_write: cover property (wr_access && idx == `IDX_PORT_B_DATA
                                 && state.regs.enable_high != 8'h00);
   cov_all_groups: cover property (group_fire == 4'hF);
endmodule : pulse_pattern

// *** src/trigger_route.sv ***
// Routes the three compare-match strobes to the four output groups
`timescale 1ns/100ps
`include "pattern_params.svh"
module trigger_route
(
   input wire logic [7:0] trigger_select,
   input wire logic [2:0] compare_match,
   output logic [3:0] group_fire,
   output logic [3:0][1:0] group_channel
);
   // Codes 10 and 11 both pick channel 2
   function automatic logic [1:0] channel_of(input logic [1:0] sel);
      channel_of = sel[1] ? `SEL_CH2 : sel;
   endfunction : channel_of

   always_comb
   begin
      for (int g = 0; g < 4; g++)
      begin
         group_channel[g] = channel_of(trigger_select[g*`SEL_W +: `SEL_W]);
         group_fire[g] = compare_match[group_channel[g]];
      end
   end
endmodule : trigger_route
